// ===== src/sfs_flash_core.sv
// Serial flash command engine: status register access and array read instructions
`timescale 1ns/10ps
`default_nettype none

module sfs_flash_core #(
	parameter int ADDR_W = sfs_pkg::ADDR_BITS,
	parameter int unsigned WRITE_CYCLES = sfs_pkg::STATUS_WRITE_CYCLES
) (
	input wire logic clk_sys, // System clock, 250 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic sck, // Serial clock from the host
	input wire logic cs_n, // Chip select, active low
	input wire logic [3:0] lane_in, // Input side of lanes three to zero
	output logic [3:0] lane_out, // Output side of lanes three to zero
	output logic [3:0] lane_oe, // Lane output enables, high drives
	input wire logic mem_load_en, // Preload strobe for the array
	input wire logic [ADDR_W-1:0] mem_load_addr, // Preload byte address
	input wire logic [7:0] mem_load_data, // Preload byte
	output logic [7:0] status_low_o, // Low status register
	output logic [7:0] status_high_o // High status register
);
	localparam int MEM_BYTES = 1 << ADDR_W;
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	logic rst_n;
	logic cs_sync;
	logic cs_prev_reg;
	logic frame_end;
	logic frame_rst_n;
	logic [7:0] mem_array [MEM_BYTES];
	sfs_pkg::sfs_phase_t phase_reg;
	sfs_pkg::sfs_phase_t phase_dec;
	sfs_pkg::sfs_lanes_t lanes_reg;
	sfs_pkg::sfs_lanes_t lanes_dec;
	logic sel_high_reg;
	logic sel_high_dec;
	logic [5:0] cnt_reg;
	logic [7:0] op_reg;
	logic [7:0] op_shift;
	logic [23:0] addr_reg;
	logic [5:0] addr_last;
	logic [5:0] dummy_last;
	sfs_pkg::sfs_cmd_t cap_reg;
	sfs_pkg::sfs_status_t st_link;
	logic loaded_reg;
	logic [7:0] sr_reg;
	logic [2:0] left_reg;
	logic [23:0] rd_addr_reg;
	logic need_load;
	logic [23:0] addr_cur;
	logic [7:0] byte_src;
	logic [7:0] cur_byte;
	logic tx_active;
	logic [7:0] st_low_reg;
	logic [7:0] st_high_reg;
	logic vol_en_reg;
	logic [CW-1:0] busy_cnt_reg;
	logic busy_done;
	logic wr_len_ok;
	logic wr_long;
	logic [7:0] lo_in;
	logic [7:0] hi_in;
	logic [7:0] lo_next;
	logic [7:0] hi_next;
	// Enables over drive pattern for one clock: top bits of the remaining byte on the active lanes
	function automatic logic [7:0] lane_drive(input sfs_pkg::sfs_lanes_t m, input logic [7:0] b);
		case (m)
			sfs_pkg::LN_DUAL: lane_drive = {4'h3, 2'b00, b[7], b[6]};
			sfs_pkg::LN_QUAD: lane_drive = {4'hf, b[7:4]};
			default: lane_drive = {4'h2, 2'b00, b[7], 1'b0};
		endcase
	endfunction

	function automatic logic [7:0] shift_out(input sfs_pkg::sfs_lanes_t m, input logic [7:0] b);
		case (m)
			sfs_pkg::LN_DUAL: shift_out = {b[5:0], 2'b00};
			sfs_pkg::LN_QUAD: shift_out = {b[3:0], 4'h0};
			default: shift_out = {b[6:0], 1'b0};
		endcase
	endfunction

	function automatic logic [2:0] chunks_after_load(input sfs_pkg::sfs_lanes_t m);
		case (m)
			sfs_pkg::LN_DUAL: chunks_after_load = 3'h3;
			sfs_pkg::LN_QUAD: chunks_after_load = 3'h1;
			default: chunks_after_load = 3'h7;
		endcase
	endfunction

	sfs_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
		.clk(clk_sys),
		.rst_n(arst_n),
		.d(1'b1),
		.q(rst_n)
	);
	sfs_sync #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
		.clk(clk_sys),
		.rst_n(rst_n),
		.d(cs_n),
		.q(cs_sync)
	);
	// Status is quasi-static on the link side; it settles within two serial clocks of a frame
	sfs_sync #(.WIDTH(16), .INIT(16'h0000)) u_status_sync (
		.clk(sck),
		.rst_n(rst_n),
		.d({st_high_reg, st_low_reg}),
		.q(st_link)
	);
	// Raising chip select clears all frame state but the capture, so no serial edge is needed to end it
	assign frame_rst_n = rst_n & ~cs_n;
	assign op_shift = {op_reg[6:0], lane_in[0]};
	assign addr_last = (op_reg == sfs_pkg::OP_DUAL_IO) ? sfs_pkg::ADDR_LAST_DUAL : sfs_pkg::ADDR_LAST_SINGLE;
	assign dummy_last = (op_reg == sfs_pkg::OP_DUAL_IO) ? sfs_pkg::MODE_LAST_DUAL : sfs_pkg::DUMMY_LAST;

	always_comb
	begin
		phase_dec = sfs_pkg::PH_IGNORE;
		lanes_dec = sfs_pkg::LN_SINGLE;
		sel_high_dec = 1'b0;
		case (op_shift)
			sfs_pkg::OP_RD_SR_LOW: phase_dec = sfs_pkg::PH_STATUS;
			sfs_pkg::OP_RD_SR_HIGH:
			begin
				phase_dec = sfs_pkg::PH_STATUS;
				sel_high_dec = 1'b1;
			end
			sfs_pkg::OP_WR_SR: phase_dec = sfs_pkg::PH_WDATA;
			sfs_pkg::OP_READ, sfs_pkg::OP_FAST:
				phase_dec = st_link.low[sfs_pkg::LO_BUSY] ? sfs_pkg::PH_IGNORE : sfs_pkg::PH_ADDR;
			sfs_pkg::OP_DUAL_OUT, sfs_pkg::OP_DUAL_IO:
			begin
				phase_dec = st_link.low[sfs_pkg::LO_BUSY] ? sfs_pkg::PH_IGNORE : sfs_pkg::PH_ADDR;
				lanes_dec = sfs_pkg::LN_DUAL;
			end
			sfs_pkg::OP_QUAD_OUT:
			begin
				if (st_link.high[sfs_pkg::HI_QUAD_EN] && !st_link.low[sfs_pkg::LO_BUSY])
					phase_dec = sfs_pkg::PH_ADDR;
				lanes_dec = sfs_pkg::LN_QUAD;
			end
			default: phase_dec = sfs_pkg::PH_IGNORE;
		endcase
	end

	// Instruction, address and dummy phases, sampled on rising serial edges
	always_ff @(posedge sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			phase_reg <= sfs_pkg::PH_OPCODE;
			lanes_reg <= sfs_pkg::LN_SINGLE;
			sel_high_reg <= 1'b0;
			cnt_reg <= 6'h00;
			op_reg <= 8'h00;
			addr_reg <= 24'h000000;
		end
		else
		begin
			unique case (phase_reg)
				sfs_pkg::PH_OPCODE:
				begin
					op_reg <= op_shift;
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == sfs_pkg::OPCODE_LAST)
					begin
						cnt_reg <= 6'h00;
						phase_reg <= phase_dec;
						lanes_reg <= lanes_dec;
						sel_high_reg <= sel_high_dec;
					end
				end
				sfs_pkg::PH_ADDR:
				begin
					if (op_reg == sfs_pkg::OP_DUAL_IO)
						addr_reg <= {addr_reg[21:0], lane_in[1], lane_in[0]};
					else
						addr_reg <= {addr_reg[22:0], lane_in[0]};
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == addr_last)
					begin
						cnt_reg <= 6'h00;
						phase_reg <= (op_reg == sfs_pkg::OP_READ) ? sfs_pkg::PH_DATA : sfs_pkg::PH_DUMMY;
					end
				end
				sfs_pkg::PH_DUMMY:
				begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == dummy_last)
					begin
						cnt_reg <= 6'h00;
						phase_reg <= sfs_pkg::PH_DATA;
					end
				end
				sfs_pkg::PH_DATA, sfs_pkg::PH_STATUS, sfs_pkg::PH_WDATA, sfs_pkg::PH_IGNORE:
					phase_reg <= phase_reg;
				default: phase_reg <= sfs_pkg::PH_IGNORE;
			endcase
		end
	end

	// Capture outlives chip select; a new frame must wait four system clocks after it rises
	always_ff @(posedge sck or negedge rst_n)
	begin
		if (!rst_n)
			cap_reg <= '0;
		else if (phase_reg == sfs_pkg::PH_OPCODE && frame_rst_n)
		begin
			cap_reg.opcode <= (cnt_reg == sfs_pkg::OPCODE_LAST) ? op_shift : sfs_pkg::OP_NONE;
			cap_reg.bits <= 6'h00;
		end
		else if (phase_reg == sfs_pkg::PH_WDATA && frame_rst_n)
		begin
			cap_reg.data <= {cap_reg.data[14:0], lane_in[0]};
			if (cap_reg.bits != sfs_pkg::BITS_SAT)
				cap_reg.bits <= cap_reg.bits + 6'h01;
		end
	end
	// Output side: falling serial edges; dummy clocks leave every lane released
	assign tx_active = (phase_reg == sfs_pkg::PH_DATA) || (phase_reg == sfs_pkg::PH_STATUS);
	assign need_load = !loaded_reg || (left_reg == 3'h0);
	assign addr_cur = loaded_reg ? rd_addr_reg : addr_reg;
	assign byte_src = (phase_reg == sfs_pkg::PH_STATUS) ?
		(sel_high_reg ? st_link.high : st_link.low) : mem_array[addr_cur[ADDR_W-1:0]];
	assign cur_byte = need_load ? byte_src : sr_reg;

	always_ff @(negedge sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			loaded_reg <= 1'b0;
			sr_reg <= 8'h00;
			left_reg <= 3'h0;
			rd_addr_reg <= 24'h000000;
			lane_out <= 4'h0;
			lane_oe <= 4'h0;
		end
		else if (!tx_active)
		begin
			lane_out <= 4'h0;
			lane_oe <= 4'h0;
		end
		else
		begin
			{lane_oe, lane_out} <= lane_drive(lanes_reg, cur_byte);
			sr_reg <= shift_out(lanes_reg, cur_byte);
			left_reg <= need_load ? chunks_after_load(lanes_reg) : left_reg - 3'h1;
			loaded_reg <= 1'b1;
			if (need_load && phase_reg == sfs_pkg::PH_DATA)
				rd_addr_reg <= addr_cur + 24'h000001;
		end
	end
	// Preload port for the array contents; only use it while chip select is high
	always_ff @(posedge clk_sys)
	begin
		if (mem_load_en)
			mem_array[mem_load_addr] <= mem_load_data;
	end
	// System side: act on the captured command once chip select has risen
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cs_prev_reg <= 1'b1;
		else
			cs_prev_reg <= cs_sync;
	end
	assign frame_end = cs_sync & ~cs_prev_reg;
	assign wr_long = (cap_reg.bits == sfs_pkg::WSR_LONG_BITS);
	assign wr_len_ok = wr_long || (cap_reg.bits == sfs_pkg::WSR_SHORT_BITS);
	assign lo_in = wr_long ? cap_reg.data[15:8] : cap_reg.data[7:0];
	assign hi_in = wr_long ? cap_reg.data[7:0] : 8'h00;
	assign lo_next = (st_low_reg & ~sfs_pkg::LOW_WR_MASK) | (lo_in & sfs_pkg::LOW_WR_MASK);
	// Locks are OR-ed back in always; the high protect bit is also held on the volatile path
	assign hi_next = (st_high_reg & ~sfs_pkg::HIGH_WR_MASK) | (hi_in & sfs_pkg::HIGH_WR_MASK)
		| (st_high_reg & sfs_pkg::LOCK_MASK)
		| (st_low_reg[sfs_pkg::LO_WR_LATCH] ? 8'h00 : (st_high_reg & sfs_pkg::PROT_HIGH_MASK));
	assign busy_done = st_low_reg[sfs_pkg::LO_BUSY] && (busy_cnt_reg == '0);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			busy_cnt_reg <= '0;
		else if (frame_end && !st_low_reg[sfs_pkg::LO_BUSY] && cap_reg.opcode == sfs_pkg::OP_WR_SR
			&& wr_len_ok && st_low_reg[sfs_pkg::LO_WR_LATCH])
			busy_cnt_reg <= CW'(WRITE_CYCLES - 1);
		else if (busy_cnt_reg != '0)
			busy_cnt_reg <= busy_cnt_reg - CW'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_low_reg <= sfs_pkg::STATUS_LOW_RESET;
			st_high_reg <= sfs_pkg::STATUS_HIGH_RESET;
			vol_en_reg <= 1'b0;
		end
		else if (busy_done)
		begin
			st_low_reg[sfs_pkg::LO_BUSY] <= 1'b0;
			st_low_reg[sfs_pkg::LO_WR_LATCH] <= 1'b0;
		end
		else if (frame_end && !st_low_reg[sfs_pkg::LO_BUSY])
		begin
			case (cap_reg.opcode)
				sfs_pkg::OP_WREN: st_low_reg[sfs_pkg::LO_WR_LATCH] <= 1'b1;
				sfs_pkg::OP_WRDI:
				begin
					st_low_reg[sfs_pkg::LO_WR_LATCH] <= 1'b0;
					vol_en_reg <= 1'b0;
				end
				sfs_pkg::OP_VOL_WREN: vol_en_reg <= 1'b1;
				sfs_pkg::OP_WR_SR:
				begin
					if (wr_len_ok && (st_low_reg[sfs_pkg::LO_WR_LATCH] || vol_en_reg))
					begin
						st_low_reg <= lo_next | (st_low_reg & 8'h03);
						st_high_reg <= hi_next;
						if (st_low_reg[sfs_pkg::LO_WR_LATCH])
							st_low_reg[sfs_pkg::LO_BUSY] <= 1'b1;
						vol_en_reg <= 1'b0;
					end
				end
				default: vol_en_reg <= vol_en_reg;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_low_o <= sfs_pkg::STATUS_LOW_RESET;
			status_high_o <= sfs_pkg::STATUS_HIGH_RESET;
		end
		else
		begin
			status_low_o <= st_low_reg;
			status_high_o <= st_high_reg;
		end
	end
endmodule
`default_nettype wire

// ===== src/sfs_pkg.sv
// Shared constants, encodings and carrier types of the serial flash status and read command block
package sfs_pkg;
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_RD_SR_LOW = 8'h05;
	localparam logic [7:0] OP_RD_SR_HIGH = 8'h35;
	localparam logic [7:0] OP_WR_SR = 8'h01;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VOL_WREN = 8'h50;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;

	// Low status byte fields
	localparam int LO_BUSY = 0;
	localparam int LO_WR_LATCH = 1;
	// High status byte fields (bit 8 of the status word is bit 0 here)
	localparam int HI_PROT_HIGH = 0;
	localparam int HI_QUAD_EN = 1;
	localparam logic [7:0] LOW_WR_MASK = 8'hfc;
	localparam logic [7:0] HIGH_WR_MASK = 8'h7f;
	localparam logic [7:0] LOCK_MASK = 8'h3c;
	localparam logic [7:0] PROT_HIGH_MASK = 8'h01;
	localparam logic [7:0] STATUS_LOW_RESET = 8'h00;
	localparam logic [7:0] STATUS_HIGH_RESET = 8'h00;

	localparam int ADDR_BITS = 24;
	localparam logic [5:0] OPCODE_LAST = 6'h07;
	localparam logic [5:0] ADDR_LAST_SINGLE = 6'h17;
	localparam logic [5:0] ADDR_LAST_DUAL = 6'h0b;
	localparam logic [5:0] DUMMY_LAST = 6'h07;
	localparam logic [5:0] MODE_LAST_DUAL = 6'h03;
	localparam logic [5:0] WSR_SHORT_BITS = 6'h08;
	localparam logic [5:0] WSR_LONG_BITS = 6'h10;
	localparam logic [5:0] BITS_SAT = 6'h3f;

	localparam int CLK_SYS_MHZ = 250;
	localparam int STATUS_WRITE_TIME_US = 10;
	localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_SYS_MHZ;

	typedef enum logic [2:0] {
		PH_OPCODE = 3'b000,
		PH_ADDR = 3'b001,
		PH_DUMMY = 3'b010,
		PH_DATA = 3'b011,
		PH_STATUS = 3'b100,
		PH_WDATA = 3'b101,
		PH_IGNORE = 3'b110
	} sfs_phase_t;

	typedef enum logic [1:0] {
		LN_SINGLE = 2'b00,
		LN_DUAL = 2'b01,
		LN_QUAD = 2'b10
	} sfs_lanes_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [15:0] data;
		logic [5:0] bits;
	} sfs_cmd_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} sfs_status_t;
endpackage

// ===== src/sfs_sync.sv
// Two-flop synchroniser with a chosen reset value
`timescale 1ns/10ps
`default_nettype none
module sfs_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk, // Destination clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [WIDTH-1:0] d, // Asynchronous input
	output logic [WIDTH-1:0] q // Synchronised output
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= INIT;
			q <= INIT;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/sfs_checker.sv
// Port-level assertions for the flash command engine
`timescale 1ns/10ps
`default_nettype none
module sfs_checker #(
	parameter int ADDR_W = 24,
	parameter int unsigned WRITE_CYCLES = 2500
) (
	input wire logic clk_sys, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic sck, // Serial clock
	input wire logic cs_n, // Chip select, active low
	input wire logic [3:0] lane_in, // Lane inputs
	input wire logic [3:0] lane_out, // Lane outputs
	input wire logic [3:0] lane_oe, // Lane enables
	input wire logic mem_load_en, // Preload strobe
	input wire logic [ADDR_W-1:0] mem_load_addr, // Preload address
	input wire logic [7:0] mem_load_data, // Preload byte
	input wire logic [7:0] status_low_o, // Low status
	input wire logic [7:0] status_high_o // High status
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	idle_release_a: assert property (cs_n |-> lane_oe == 4'h0) else $error("lanes driven while deselected");
	oe_shape_a: assert property (lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad lane set");
	quad_gate_a: assert property (lane_oe == 4'hf |-> status_high_o[1]) else $error("quad without enable");
	busy_read_a: assert property (lane_oe[0] |-> !status_low_o[0]) else $error("array read while busy");
	busy_latch_a: assert property ($rose(status_low_o[0]) |-> status_low_o[1]) else $error("busy without latch");
	busy_span_a: assert property ($rose(status_low_o[0]) |=> status_low_o[0] [*8]) else $error("busy too short");
	busy_end_a: assert property ($fell(status_low_o[0]) |-> !status_low_o[1]) else $error("latch kept");
	lock_keep_a: assert property ((($past(status_high_o) & ~status_high_o) & sfs_pkg::LOCK_MASK) == 8'h00)
		else $error("lock bit cleared");
	ro_bit_a: assert property (status_high_o[7] == 1'b0) else $error("read-only bit set");
	cover property ($fell(status_low_o[0]));
	cover property (lane_oe == 4'hf);
	cover property (lane_oe == 4'h3 ##1 cs_n);
endmodule
bind sfs_flash_core sfs_checker #(.ADDR_W(ADDR_W), .WRITE_CYCLES(WRITE_CYCLES)) chk_i (.clk_sys(clk_sys),
	.arst_n(arst_n), .sck(sck), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe),
	.mem_load_en(mem_load_en), .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
	.status_low_o(status_low_o), .status_high_o(status_high_o));
`default_nettype wire

// ===== testbench/sfs_host.sv
// Host serial master model for the flash link
`timescale 1ns/10ps
`default_nettype none
module sfs_host (
	output logic sck, // Serial clock, idle low
	output logic cs_n, // Chip select, active low
	output logic [3:0] lane_in, // Wire level seen by the device
	input wire logic [3:0] lane_out, // Device lane values
	input wire logic [3:0] lane_oe // Device lane enables
);
	logic [3:0] hdrv;
	logic [3:0] hen;
	logic junk;
	// Released lanes wander so a stale bit never passes for data
	assign lane_in = (lane_oe & lane_out) | (~lane_oe & hen & hdrv) | (~lane_oe & ~hen & {4{junk}});
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		hdrv = 4'h0;
		hen = 4'h0;
		junk = 1'b0;
	end
	task automatic start();
		cs_n = 1'b0;
		#15;
	endtask
	// MSB first; in pairs the odd bit rides on lane one
	task automatic xfer(input logic [31:0] tx, input int n, input int w, input bit drv, inout logic [31:0] rx);
		for (int k = 0; k < n; k++)
		begin
			hdrv = 4'((tx >> ((n - 1 - k) * w)) & 32'h3);
			hen = drv ? ((w == 1) ? 4'h1 : 4'h3) : 4'h0;
			#15 sck = 1'b1;
			rx = (rx << w) | 32'((w == 1) ? {3'h0, lane_in[1]} : (w == 2) ? {2'h0, lane_in[1:0]} : lane_in);
			#2 hen = 4'h0;
			#13 sck = 1'b0;
			junk = ~junk;
		end
	endtask
	task automatic stop();
		#15 cs_n = 1'b1;
		#45;
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the flash status and read commands
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys;
	logic arst_n;
	logic sck;
	logic cs_n;
	logic [3:0] lane_in;
	logic [3:0] lane_out;
	logic [3:0] lane_oe;
	logic mem_load_en;
	logic [7:0] mem_load_addr;
	logic [7:0] mem_load_data;
	logic [7:0] status_low_o;
	logic [7:0] status_high_o;
	logic seen_oe;
	logic [31:0] rx;
	int failures;
	int num_checks;
	sfs_flash_core #(.ADDR_W(8), .WRITE_CYCLES(2000)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck),
		.cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .mem_load_en(mem_load_en),
		.mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data), .status_low_o(status_low_o),
		.status_high_o(status_high_o));
	sfs_host host (.sck(sck), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		if (lane_oe != 4'h0)
			seen_oe <= 1'b1;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic load(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		mem_load_en <= 1'b1;
		mem_load_addr <= a;
		mem_load_data <= d;
		@(posedge clk_sys);
		mem_load_en <= 1'b0;
	endtask
	// Opcode, address in aw-bit steps, dummy clocks, then nd clocks of w lanes
	task automatic frame(input logic [7:0] op, input int aw, input int dm, input int w, input int nd,
		input logic [31:0] tx);
		seen_oe = 1'b0;
		rx = '0;
		host.start();
		host.xfer(32'(op), 8, 1, 1'b1, rx);
		if (aw > 0)
			host.xfer(tx, 24 / aw, aw, 1'b1, rx);
		if (dm > 0)
			host.xfer(32'h0, dm, 1, 1'b1, rx);
		rx = '0;
		host.xfer(tx, nd, w, aw == 0, rx);
		host.stop();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 3000 && status_low_o[0] !== 1'b0; i++)
			@(posedge clk_sys);
		chk("busy end", 32'(status_low_o[0]), 32'h0);
	endtask
	task automatic t_reads();
		frame(sfs_pkg::OP_READ, 1, 0, 1, 16, 32'hff);
		chk("read wrap", rx, 32'ha53c);
		frame(sfs_pkg::OP_FAST, 1, 8, 1, 8, 32'h10);
		chk("fast", rx, 32'h96);
		frame(sfs_pkg::OP_DUAL_OUT, 1, 8, 2, 4, 32'h10);
		chk("dual out", rx, 32'h96);
		frame(sfs_pkg::OP_DUAL_IO, 2, 4, 2, 4, 32'h10);
		chk("dual io", rx, 32'h96);
		frame(sfs_pkg::OP_QUAD_OUT, 1, 8, 4, 2, 32'h10);
		chk("quad off", seen_oe, 32'h0);
	endtask
	task automatic t_guard();
		frame(sfs_pkg::OP_WR_SR, 0, 0, 1, 16, 32'hfcff);
		chk("no latch", {status_high_o, status_low_o}, 32'h0);
		frame(sfs_pkg::OP_WREN, 0, 0, 1, 0, 32'h0);
		chk("latch", {status_high_o, status_low_o}, 32'h2);
		frame(sfs_pkg::OP_WR_SR, 0, 0, 1, 12, 32'hfcf);
		chk("cut short", {status_high_o, status_low_o}, 32'h2);
		frame(sfs_pkg::OP_WRDI, 0, 0, 1, 0, 32'h0);
		chk("disabled", {status_high_o, status_low_o}, 32'h0);
	endtask
	task automatic t_nv();
		frame(sfs_pkg::OP_WREN, 0, 0, 1, 0, 32'h0);
		frame(sfs_pkg::OP_WR_SR, 0, 0, 1, 16, 32'h5cff);
		chk("busy", status_low_o, 32'h5f);
		frame(sfs_pkg::OP_RD_SR_LOW, 0, 0, 1, 16, 32'h0);
		chk("poll low", rx, 32'h5f5f);
		frame(sfs_pkg::OP_RD_SR_HIGH, 0, 0, 1, 8, 32'h0);
		chk("poll high", rx, 32'h7f);
		frame(sfs_pkg::OP_READ, 1, 0, 1, 8, 32'h10);
		chk("read busy", seen_oe, 32'h0);
		wait_idle();
		chk("written", {status_high_o, status_low_o}, 32'h7f5c);
		frame(sfs_pkg::OP_QUAD_OUT, 1, 8, 4, 2, 32'h10);
		chk("quad", rx, 32'h96);
	endtask
	task automatic t_vol();
		frame(sfs_pkg::OP_VOL_WREN, 0, 0, 1, 0, 32'h0);
		frame(sfs_pkg::OP_WR_SR, 0, 0, 1, 16, 32'h0);
		chk("volatile", {status_high_o, status_low_o}, 32'h3d00);
	endtask
	task automatic t_short();
		frame(sfs_pkg::OP_WREN, 0, 0, 1, 0, 32'h0);
		frame(sfs_pkg::OP_WR_SR, 0, 0, 1, 8, 32'h04);
		wait_idle();
		chk("eight bit", {status_high_o, status_low_o}, 32'h3c04);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		mem_load_en = 1'b0;
		mem_load_addr = 8'h00;
		mem_load_data = 8'h00;
		seen_oe = 1'b0;
		failures = 0;
		num_checks = 0;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("reset", {status_high_o, status_low_o}, 32'h0);
		load(8'hff, 8'ha5);
		load(8'h00, 8'h3c);
		load(8'h10, 8'h96);
		t_reads();
		t_guard();
		t_nv();
		t_vol();
		t_short();
		test_done();
	end
	// Roughly ten times the expected run
	initial
	begin
		#300000;
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
